// File: logic/xbe_crossbar.sv
// Purpose: crossbar peripheral enable registers plus priority pin assignment
// Assumes: pins 0..7 form the first port; bypass mask and global enable come from same-clock logic
// Notes: every top output is registered, so pin changes show one cycle after a register write
`timescale 1ns/1ns
`include "xbe_consts.svh"
module xbe_crossbar #(
    parameter int NUM_PINS = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    // special-function-register bus
    input wire xbe_pkg::xbe_sfr_addr_t sfrAddr,
    input wire xbe_pkg::xbe_byte_t sfrPage,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire xbe_pkg::xbe_byte_t sfrWdata,
    output xbe_pkg::xbe_byte_t sfrRdata,
    // crossbar context from neighbouring registers and peripherals
    input wire logic matrixGlobalEn,
    input wire logic linPinsEn,
    input wire logic spiNssUsed,
    input wire logic [NUM_PINS-1:0] pinBypassMask,
    // peripheral side, one bit per function slot
    input wire logic [`XBE_NUM_FUNC-1:0] funcOut,
    input wire logic [`XBE_NUM_FUNC-1:0] funcOe,
    output logic [`XBE_NUM_FUNC-1:0] funcIn,
    // plain port latch for unassigned pins
    input wire logic [NUM_PINS-1:0] portOut,
    input wire logic [NUM_PINS-1:0] portOe,
    output logic [NUM_PINS-1:0] portIn,
    // pad side
    input wire logic [NUM_PINS-1:0] pinIn,
    output logic [NUM_PINS-1:0] pinOut,
    output logic [NUM_PINS-1:0] pinOe
);
    import xbe_pkg::*;

    // one slot per peripheral signal; slot order is the priority order
    localparam int NF = `XBE_NUM_FUNC;

    xbe_byte_t enableLow_q;            // crossbar_enable_low
    xbe_byte_t enableHigh_q;           // crossbar_enable_high
    logic [2:0] captCount;             // capture output count field
    logic [NF-1:0] fnEn;               // function wants pins
    logic [NUM_PINS-1:0] pinSync;      // synchronised pad levels
    logic [NUM_PINS-1:0] pinOwned;     // pin given to some function
    xbe_func_idx_t pinOwner [NUM_PINS]; // which function owns the pin
    logic [NF-1:0] funcIn_d;           // pad level seen by each function
    logic sfrHit;                      // bus access on our page

    // pad levels cross into the clock domain first
    // nothing reads the raw pads, which may change at any moment
    xbe_sync2 #(
        .WIDTH(NUM_PINS)
    ) u_pinSync (
        .clk(clk),
        .rst_n(rst_n),
        .async(pinIn),
        .sync(pinSync)
    );

    // only the crossbar page answers; any other page leaves the registers alone
    assign sfrHit = (sfrPage == `XBE_SFR_PAGE);
    assign captCount = enableHigh_q[`XBE_CAPT_MSB:`XBE_CAPT_LSB];

    // register writes; the reserved high bit 0 is never stored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enableLow_q <= `XBE_ENABLE_LOW_RESET; // RULE_17
            enableHigh_q <= `XBE_ENABLE_HIGH_RESET; // RULE_17
        end else if (sfrWrite && sfrHit) begin
            // low enables: comparators, SMBus, SPI, CAN and UART
            if (sfrAddr == `XBE_ADDR_ENABLE_LOW) begin
                enableLow_q <= sfrWdata;
            end
            // high enables: timers, count input, capture count, clock out
            // the reserved bit is dropped so software never reads back a one
            if (sfrAddr == `XBE_ADDR_ENABLE_HIGH) begin
                enableHigh_q <= sfrWdata & `XBE_ENABLE_HIGH_MASK;
            end
        end
    end

    // read data is registered; other addresses answer zero
    // zero rather than stale data, so a missed read never looks valid
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sfrRdata <= 8'h00;
        end else if (sfrRead && sfrHit && sfrAddr == `XBE_ADDR_ENABLE_LOW) begin
            sfrRdata <= enableLow_q;
        end else if (sfrRead && sfrHit && sfrAddr == `XBE_ADDR_ENABLE_HIGH) begin
            sfrRdata <= enableHigh_q;
        end else begin
            sfrRdata <= 8'h00;
        end
    end

    // decode register bits into per-function requests
    always_comb begin
        fnEn = '0;
        // two-wire peripherals raise both slots from one enable bit
        fnEn[`XBE_FN_UART_TX] = enableLow_q[`XBE_BIT_UART]; // RULE_08
        fnEn[`XBE_FN_UART_RX] = enableLow_q[`XBE_BIT_UART]; // RULE_16
        fnEn[`XBE_FN_CAN_TX] = enableLow_q[`XBE_BIT_CAN]; // RULE_07
        fnEn[`XBE_FN_CAN_RX] = enableLow_q[`XBE_BIT_CAN]; // RULE_16
        // the LIN pair is requested by a neighbouring register
        fnEn[`XBE_FN_LIN_TX] = linPinsEn; // RULE_16
        fnEn[`XBE_FN_LIN_RX] = linPinsEn;
        // SPI claims three pins, or four when slave select is in use
        fnEn[`XBE_FN_SPI_SCK] = enableLow_q[`XBE_BIT_SPI]; // RULE_06
        fnEn[`XBE_FN_SPI_MISO] = enableLow_q[`XBE_BIT_SPI];
        fnEn[`XBE_FN_SPI_MOSI] = enableLow_q[`XBE_BIT_SPI];
        // slave select only in four-wire mode
        fnEn[`XBE_FN_SPI_NSS] = enableLow_q[`XBE_BIT_SPI] & spiNssUsed; // RULE_06
        fnEn[`XBE_FN_SMB_SDA] = enableLow_q[`XBE_BIT_SMBUS]; // RULE_05
        fnEn[`XBE_FN_SMB_SCL] = enableLow_q[`XBE_BIT_SMBUS]; // RULE_16
        // comparator outputs are single pins each
        fnEn[`XBE_FN_COMP_A] = enableLow_q[`XBE_BIT_COMP_A]; // RULE_04
        fnEn[`XBE_FN_COMP_A_ASYNC] = enableLow_q[`XBE_BIT_COMP_A_ASYNC]; // RULE_03
        fnEn[`XBE_FN_COMP_B] = enableLow_q[`XBE_BIT_COMP_B]; // RULE_02
        fnEn[`XBE_FN_COMP_B_ASYNC] = enableLow_q[`XBE_BIT_COMP_B_ASYNC]; // RULE_01
        // the system clock output is one more single-pin function
        fnEn[`XBE_FN_CLOCK_OUT] = enableHigh_q[`XBE_BIT_CLOCK_OUT]; // RULE_13
        // reserved count routes nothing rather than guessing a width
        for (int i = 0; i < `XBE_NUM_CAPT; i++) begin
            fnEn[`XBE_FN_CAPT0 + i] = (captCount != `XBE_CAPT_RESERVED) && (int'(captCount) > i); // RULE_12
        end
        // timer and count inputs sit at the lowest priority
        fnEn[`XBE_FN_COUNT_IN] = enableHigh_q[`XBE_BIT_COUNT_IN]; // RULE_11
        fnEn[`XBE_FN_TIMER_A] = enableHigh_q[`XBE_BIT_TIMER_A]; // RULE_10
        fnEn[`XBE_FN_TIMER_B] = enableHigh_q[`XBE_BIT_TIMER_B]; // RULE_09
    end

    // priority walk: fixed pins first, then lowest free pin per function
    always_comb begin
        logic [NUM_PINS-1:0] taken;
        logic found;
        // skipped pins start out looking as if already assigned
        taken = pinBypassMask;
        found = 1'b0;
        pinOwned = '0;
        for (int p = 0; p < NUM_PINS; p++) begin
            pinOwner[p] = '0;
        end
        // fixed positions ignore the bypass mask
        // so a skipped fixed pin is still handed to its peripheral
        if (fnEn[`XBE_FN_UART_TX]) begin
            pinOwned[`XBE_PIN_UART_TX] = 1'b1; // RULE_08
            pinOwner[`XBE_PIN_UART_TX] = xbe_func_idx_t'(`XBE_FN_UART_TX);
            pinOwned[`XBE_PIN_UART_RX] = 1'b1;
            pinOwner[`XBE_PIN_UART_RX] = xbe_func_idx_t'(`XBE_FN_UART_RX);
            taken[`XBE_PIN_UART_TX] = 1'b1;
            taken[`XBE_PIN_UART_RX] = 1'b1;
        end
        if (fnEn[`XBE_FN_CAN_TX]) begin
            pinOwned[`XBE_PIN_CAN_TX] = 1'b1; // RULE_07
            pinOwner[`XBE_PIN_CAN_TX] = xbe_func_idx_t'(`XBE_FN_CAN_TX);
            pinOwned[`XBE_PIN_CAN_RX] = 1'b1;
            pinOwner[`XBE_PIN_CAN_RX] = xbe_func_idx_t'(`XBE_FN_CAN_RX);
            taken[`XBE_PIN_CAN_TX] = 1'b1;
            taken[`XBE_PIN_CAN_RX] = 1'b1;
        end
        // remaining functions in slot order take the lowest free pin
        // a function that finds no free pin is simply left off
        for (int f = `XBE_FN_LIN_TX; f < NF; f++) begin
            found = 1'b0;
            for (int p = 0; p < NUM_PINS; p++) begin
                if (fnEn[f] && !found && !taken[p]) begin
                    taken[p] = 1'b1; // RULE_14
                    pinOwned[p] = 1'b1;
                    pinOwner[p] = xbe_func_idx_t'(f);
                    found = 1'b1;
                end
            end
        end
    end

    // each function hears the pad it owns; unrouted inputs read zero
    // with the crossbar off no peripheral hears a pad
    always_comb begin
        funcIn_d = '0;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (matrixGlobalEn && pinOwned[p]) begin
                funcIn_d[pinOwner[p]] = pinSync[p]; // RULE_15
            end
        end
    end

    // pad drive; with the crossbar off every driver is released
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // no driver is enabled while reset is held
            pinOut <= '0;
            pinOe <= '0;
        end else begin
            for (int p = 0; p < NUM_PINS; p++) begin
                if (!matrixGlobalEn) begin
                    pinOut[p] <= 1'b0; // RULE_15
                    pinOe[p] <= 1'b0; // RULE_15
                end else if (pinOwned[p]) begin
                    // an owned pin follows its peripheral's drive and enable
                    pinOut[p] <= funcOut[pinOwner[p]];
                    pinOe[p] <= funcOe[pinOwner[p]];
                end else begin
                    // unassigned pins fall back to the plain port latch
                    pinOut[p] <= portOut[p];
                    pinOe[p] <= portOe[p];
                end
            end
        end
    end

    // synchronised levels back to peripherals and port latch
    // the port latch keeps seeing the pads even with the crossbar off
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            funcIn <= '0;
            portIn <= '0;
        end else begin
            funcIn <= funcIn_d;
            portIn <= pinSync;
        end
    end
endmodule

// File: logic/xbe_consts.svh
// Purpose: constants for the crossbar peripheral enable block
// Assumes: 8-bit special-function-register bus, one clock
// Notes: function slot numbers give the crossbar priority order
// Behaviour
// RULE_01 - low bit 7 routes comparator B async output
// RULE_02 - low bit 6 routes comparator B output
// RULE_03 - low bit 5 routes comparator A async output
// RULE_04 - low bit 4 routes comparator A output
// RULE_05 - low bit 3 routes SMBus data and clock
// RULE_06 - low bit 2 routes SPI, three or four pins
// RULE_07 - low bit 1 puts CAN on fixed P0.6/P0.7
// RULE_08 - low bit 0 puts UART on P0.4/P0.5
// RULE_09 - high bit 7 routes timer B input
// RULE_10 - high bit 6 routes timer A input
// RULE_11 - high bit 5 routes counter array count input
// RULE_12 - high bits 4:2 count capture outputs; 111 reserved
// RULE_13 - high bit 1 routes system clock output
// RULE_14 - lowest free unskipped pin, fixed priority order
// RULE_15 - global enable clear: pins inputs, drivers off
// RULE_16 - two-wire functions claim both pins together
// RULE_17 - both enable registers reset to zero
`ifndef XBE_CONSTS_SVH
`define XBE_CONSTS_SVH

// register addresses and page
`define XBE_ADDR_ENABLE_LOW 8'hE1
`define XBE_ADDR_ENABLE_HIGH 8'hE2
`define XBE_SFR_PAGE 8'h0F
`define XBE_ENABLE_LOW_RESET 8'h00
`define XBE_ENABLE_HIGH_RESET 8'h00
// writable bits of the high register (bit 0 reserved, reads zero)
`define XBE_ENABLE_HIGH_MASK 8'hFE

// low register fields
`define XBE_BIT_COMP_B_ASYNC 7
`define XBE_BIT_COMP_B 6
`define XBE_BIT_COMP_A_ASYNC 5
`define XBE_BIT_COMP_A 4
`define XBE_BIT_SMBUS 3
`define XBE_BIT_SPI 2
`define XBE_BIT_CAN 1
`define XBE_BIT_UART 0
// high register fields
`define XBE_BIT_TIMER_B 7
`define XBE_BIT_TIMER_A 6
`define XBE_BIT_COUNT_IN 5
`define XBE_CAPT_MSB 4
`define XBE_CAPT_LSB 2
`define XBE_CAPT_RESERVED 3'h7
`define XBE_BIT_CLOCK_OUT 1

// fixed pin positions
`define XBE_PIN_UART_TX 4
`define XBE_PIN_UART_RX 5
`define XBE_PIN_CAN_TX 6
`define XBE_PIN_CAN_RX 7

// function slots, in priority order
`define XBE_FN_UART_TX 0
`define XBE_FN_UART_RX 1
`define XBE_FN_CAN_TX 2
`define XBE_FN_CAN_RX 3
`define XBE_FN_LIN_TX 4
`define XBE_FN_LIN_RX 5
`define XBE_FN_SPI_SCK 6
`define XBE_FN_SPI_MISO 7
`define XBE_FN_SPI_MOSI 8
`define XBE_FN_SPI_NSS 9
`define XBE_FN_SMB_SDA 10
`define XBE_FN_SMB_SCL 11
`define XBE_FN_COMP_A 12
`define XBE_FN_COMP_A_ASYNC 13
`define XBE_FN_COMP_B 14
`define XBE_FN_COMP_B_ASYNC 15
`define XBE_FN_CLOCK_OUT 16
`define XBE_FN_CAPT0 17
`define XBE_FN_COUNT_IN 23
`define XBE_FN_TIMER_A 24
`define XBE_FN_TIMER_B 25
`define XBE_NUM_FUNC 26
`define XBE_NUM_CAPT 6

`endif

// File: logic/xbe_pkg.sv
// Purpose: types shared by the crossbar enable block
// Assumes: constants header supplies the numbers
// Notes: none
`include "xbe_consts.svh"
package xbe_pkg;
    typedef logic [7:0] xbe_sfr_addr_t;  // special-function-register address
    typedef logic [7:0] xbe_byte_t;      // register data
    typedef logic [4:0] xbe_func_idx_t;  // function slot number
endpackage

// File: logic/xbe_sync2.sv
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: bits are independent levels
// Notes: first stage is read only by the second stage
`timescale 1ns/1ns
module xbe_sync2 #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] sync
);
    logic [WIDTH-1:0] stage1_q; // metastability catcher

    // two stages, reset to zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1_q <= '0;
            sync <= '0;
        end else begin
            stage1_q <= async;
            sync <= stage1_q;
        end
    end
endmodule

// File: testbench/xbe_crossbar_checker.sv
// Purpose: port assertions for xbe_crossbar
// Assumes: mirror registers track accepted writes
// Notes: pins lag their causes by one clock
`timescale 1ns/1ns
`include "xbe_consts.svh"
module xbe_crossbar_checker #(
    parameter int NUM_PINS = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire xbe_pkg::xbe_sfr_addr_t sfrAddr,
    input wire xbe_pkg::xbe_byte_t sfrPage,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire xbe_pkg::xbe_byte_t sfrWdata,
    input wire xbe_pkg::xbe_byte_t sfrRdata,
    input wire logic matrixGlobalEn,
    input wire logic linPinsEn,
    input wire logic [`XBE_NUM_FUNC-1:0] funcOut,
    input wire logic [`XBE_NUM_FUNC-1:0] funcOe,
    input wire logic [`XBE_NUM_FUNC-1:0] funcIn,
    input wire logic [NUM_PINS-1:0] portOut,
    input wire logic [NUM_PINS-1:0] portOe,
    input wire logic [NUM_PINS-1:0] pinOut,
    input wire logic [NUM_PINS-1:0] pinOe
);
    import xbe_pkg::*;
    xbe_byte_t enLow_q; // mirror of low enables
    xbe_byte_t enHigh_q; // mirror of high enables
    logic pageHit; // access on the crossbar page
    assign pageHit = sfrPage == `XBE_SFR_PAGE;
    // refused writes must leave the mirror alone
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enLow_q <= 8'h00;
            enHigh_q <= 8'h00;
        end else if (sfrWrite && pageHit) begin
            if (sfrAddr == `XBE_ADDR_ENABLE_LOW) enLow_q <= sfrWdata;
            if (sfrAddr == `XBE_ADDR_ENABLE_HIGH) enHigh_q <= sfrWdata & `XBE_ENABLE_HIGH_MASK;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_reset; $rose(rst_n) |-> pinOe == '0 && pinOut == '0 && sfrRdata == 8'h00; endproperty
    a_reset: assert property (p_reset) else $error("outputs not clear after reset");
    property p_off; !matrixGlobalEn |=> pinOe == '0 && pinOut == '0 && funcIn == '0; endproperty
    a_off: assert property (p_off) else $error("pins active with crossbar off");
    property p_uart; matrixGlobalEn && enLow_q[0] |=> pinOut[4] == $past(funcOut[0]) && pinOe[4] == $past(funcOe[0]);
    endproperty
    a_uart: assert property (p_uart) else $error("uart transmit not on pin 4");
    property p_can; matrixGlobalEn && enLow_q[1] |=> pinOut[6] == $past(funcOut[2]) && pinOe[6] == $past(funcOe[2]);
    endproperty
    a_can: assert property (p_can) else $error("can transmit not on pin 6");
    property p_rxOff; !enLow_q[0] |=> !funcIn[1]; endproperty
    a_rxOff: assert property (p_rxOff) else $error("uart receive seen while unrouted");
    property p_rdLow; sfrRead && pageHit && sfrAddr == `XBE_ADDR_ENABLE_LOW |=> sfrRdata == $past(enLow_q); endproperty
    a_rdLow: assert property (p_rdLow) else $error("low enable read mismatch");
    property p_rdHigh; sfrRead && pageHit && sfrAddr == `XBE_ADDR_ENABLE_HIGH |=> sfrRdata == $past(enHigh_q);
    endproperty
    a_rdHigh: assert property (p_rdHigh) else $error("high enable read mismatch");
    property p_plain; matrixGlobalEn && !linPinsEn && enLow_q == 8'h00 && enHigh_q == 8'h00
        |=> pinOut == $past(portOut) && pinOe == $past(portOe); endproperty
    a_plain: assert property (p_plain) else $error("unrouted pins not plain port");
    c_uart: cover property (matrixGlobalEn && enLow_q[0]);
    c_capFull: cover property (matrixGlobalEn && enHigh_q[4:2] == 3'h6);
    c_off: cover property (!matrixGlobalEn && enLow_q != 8'h00);
endmodule
bind xbe_crossbar xbe_crossbar_checker #(.NUM_PINS(NUM_PINS)) u_xbe_crossbar_checker (.clk, .rst_n, .sfrAddr,
    .sfrPage, .sfrWrite, .sfrRead, .sfrWdata, .sfrRdata, .matrixGlobalEn, .linPinsEn, .funcOut, .funcOe, .funcIn,
    .portOut, .portOe, .pinOut, .pinOe);

// File: testbench/xbe_periph_model.sv
// Purpose: peripherals and pads facing the crossbar
// Assumes: receive slots never drive
// Notes: a released pad reads high through its pull-up
`timescale 1ns/1ns
module xbe_periph_model (
    output logic [25:0] funcOut,
    output logic [25:0] funcOe,
    output logic [15:0] portOut,
    output logic [15:0] portOe,
    output logic [15:0] pinIn,
    input wire logic [15:0] pinOut,
    input wire logic [15:0] pinOe
);
    // even slots drive high so routed pins differ from the port latch
    assign funcOut = 26'h155_5555;
    // uart, can and lin receive slots keep their enable low
    assign funcOe = 26'h3FF_FFD5;
    // port latch drives the upper byte only
    assign portOut = 16'h5A5A;
    assign portOe = 16'hFF00;
    // undriven pad settles at the pull-up level
    assign pinIn = (pinOe & pinOut) | ~pinOe;
endmodule

// File: testbench/xbe_crossbar_tb.sv
// Purpose: directed bench for xbe_crossbar
// Assumes: inputs change at the falling edge
// Notes: pin enables of the first port judge routing
`timescale 1ns/1ns
`include "xbe_consts.svh"
module xbe_crossbar_tb;
    import xbe_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    xbe_sfr_addr_t sfrAddr = 8'h00;
    xbe_byte_t sfrPage = 8'h0F;
    xbe_byte_t sfrWdata = 8'h00;
    xbe_byte_t sfrRdata;
    logic sfrWrite = 1'b0, sfrRead = 1'b0, matrixGlobalEn = 1'b0, linPinsEn = 1'b0, spiNssUsed = 1'b0;
    logic [15:0] pinBypassMask = 16'h0000, portOut, portOe, portIn, pinIn, pinOut, pinOe;
    logic [25:0] funcOut, funcOe, funcIn;
    int failCount = 0, nCompared = 0;
    xbe_crossbar u_xbe_crossbar (.clk, .rst_n, .sfrAddr, .sfrPage, .sfrWrite, .sfrRead, .sfrWdata, .sfrRdata,
        .matrixGlobalEn, .linPinsEn, .spiNssUsed, .pinBypassMask, .funcOut, .funcOe, .funcIn, .portOut, .portOe,
        .portIn, .pinIn, .pinOut, .pinOe);
    xbe_periph_model u_xbe_periph_model (.funcOut, .funcOe, .portOut, .portOe, .pinIn, .pinOut, .pinOe);
    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            failCount++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input xbe_sfr_addr_t a, input xbe_byte_t d);
        @(negedge clk);
        sfrAddr = a;
        sfrWdata = d;
        sfrWrite = 1'b1;
        @(negedge clk);
        sfrWrite = 1'b0;
    endtask
    // read data is registered, so it is taken half a cycle after the capturing edge, as the strobe drops
    task automatic rd(input xbe_sfr_addr_t a, output xbe_byte_t d);
        @(negedge clk);
        sfrAddr = a;
        sfrRead = 1'b1;
        @(negedge clk);
        sfrRead = 1'b0;
        d = sfrRdata;
    endtask
    // load both enables and a skip mask, then judge the first port's drivers
    task automatic route(input xbe_byte_t lo, input xbe_byte_t hi, input logic [7:0] mask, input logic nss,
        input logic [7:0] exp);
        wr(`XBE_ADDR_ENABLE_LOW, lo);
        wr(`XBE_ADDR_ENABLE_HIGH, hi);
        pinBypassMask = {8'h00, mask};
        spiNssUsed = nss;
        repeat (2) @(negedge clk);
        check("pinOe", pinOe[7:0], exp);
    endtask
    task automatic t_regs();
        xbe_byte_t d;
        rd(`XBE_ADDR_ENABLE_LOW, d);
        check("low reset", d, 8'h00);
        rd(`XBE_ADDR_ENABLE_HIGH, d);
        check("high reset", d, 8'h00);
        wr(`XBE_ADDR_ENABLE_LOW, 8'hA5);
        wr(`XBE_ADDR_ENABLE_HIGH, 8'hFF);
        sfrPage = 8'h00;
        wr(`XBE_ADDR_ENABLE_LOW, 8'h00);
        sfrPage = 8'h0F;
        rd(`XBE_ADDR_ENABLE_LOW, d);
        check("low readback", d, 8'hA5);
        rd(`XBE_ADDR_ENABLE_HIGH, d);
        check("high readback", d, 8'hFE);
        rd(8'hE3, d);
        check("unmapped", d, 8'h00);
    endtask
    task automatic t_route();
        matrixGlobalEn = 1'b1;
        route(8'h80, 8'h00, 8'h00, 1'b0, 8'h01);
        route(8'h40, 8'h00, 8'h00, 1'b0, 8'h01);
        route(8'h20, 8'h00, 8'h00, 1'b0, 8'h01);
        route(8'h10, 8'h00, 8'h00, 1'b0, 8'h01);
        route(8'h08, 8'h00, 8'h00, 1'b0, 8'h03);
        route(8'h04, 8'h00, 8'h00, 1'b0, 8'h07);
        route(8'h04, 8'h00, 8'h00, 1'b1, 8'h0F);
        route(8'h02, 8'h00, 8'h00, 1'b0, 8'h40);
        route(8'h01, 8'h00, 8'h00, 1'b0, 8'h10);
        route(8'h00, 8'h80, 8'h00, 1'b0, 8'h01);
        route(8'h00, 8'h40, 8'h00, 1'b0, 8'h01);
        route(8'h00, 8'h20, 8'h00, 1'b0, 8'h01);
        route(8'h00, 8'h02, 8'h00, 1'b0, 8'h01);
        route(8'h05, 8'h00, 8'h11, 1'b0, 8'h1E);
        route(8'h06, 8'h0C, 8'h26, 1'b1, 8'h59);
        linPinsEn = 1'b1;
        route(8'h08, 8'h00, 8'h00, 1'b0, 8'h0D);
        linPinsEn = 1'b0;
    endtask
    // field stops at 6: this task never writes the reserved code
    task automatic t_capture();
        for (int n = 0; n <= 6; n++) begin
            route(8'h00, 8'(n << 2), 8'h00, 1'b0, 8'((1 << n) - 1));
        end
    endtask
    task automatic t_global();
        route(8'h01, 8'h00, 8'h00, 1'b0, 8'h10);
        repeat (3) @(negedge clk);
        check("uart receive", {7'h00, funcIn[1]}, 8'h01);
        matrixGlobalEn = 1'b0;
        route(8'hFF, 8'h00, 8'h00, 1'b0, 8'h00);
        check("receive off", {7'h00, funcIn[1]}, 8'h00);
        check("pads released low", portIn[7:0], 8'hFF);
        check("pads released high", portIn[15:8], 8'hFF);
    endtask
    // reset in mid-run clears both enables again
    task automatic t_reset();
        xbe_byte_t d;
        wr(`XBE_ADDR_ENABLE_LOW, 8'hFF);
        wr(`XBE_ADDR_ENABLE_HIGH, 8'hFE);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        rd(`XBE_ADDR_ENABLE_LOW, d);
        check("low after reset", d, 8'h00);
        rd(`XBE_ADDR_ENABLE_HIGH, d);
        check("high after reset", d, 8'h00);
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        t_regs();
        t_route();
        t_capture();
        t_global();
        t_reset();
        end_of_test();
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        failCount++;
        end_of_test();
    end
endmodule
